// ===== verilog/acr_consts.svh
// Constants for the converter control and serial readout block
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

`define ACR_CLK_PERIOD_NS 8
`define ACR_T_CONV_HS_NS 8000
`define ACR_T_CONV_SLEEP_NS 14000
`define ACR_T_WAKE_NS (`ACR_T_CONV_SLEEP_NS - `ACR_T_CONV_HS_NS)
`define ACR_T_ACQ_NS 1500
`define ACR_T_READ_QUIET_NS 400

`define ACR_CONV_HS_CYC ((`ACR_T_CONV_HS_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_WAKE_CYC ((`ACR_T_WAKE_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_CNT_W 11

`define ACR_RES_BITS 12
`define ACR_WORD_BITS 16
`define ACR_EDGE_W 5
`define ACR_FIFO_DEPTH 16
`define ACR_CS_N_RST 1'b1

`endif

// ===== verilog/acr_pkg.sv
// Types shared by the converter control and serial readout block
`include "acr_consts.svh"
package acr_pkg;
   typedef enum logic [1:0] {ACR_TRACK, ACR_CONV, ACR_PDOWN, ACR_WAKE} acr_state_t;
   typedef logic [`ACR_RES_BITS-1:0] acr_result_t;
   typedef logic [`ACR_EDGE_W-1:0] acr_edge_t;
   typedef logic [`ACR_CNT_W-1:0] acr_cnt_t;
endpackage : acr_pkg

// ===== verilog/acr_fifo_if.sv
// Handshake bundle between the result FIFO and its producer and consumer
interface acr_fifo_if #(parameter int W = 12);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;
   modport producer (output wr_valid, output wr_data, input wr_ready);
   modport consumer (input rd_valid, input rd_data, output rd_ready);
   modport fifo (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready);
endinterface : acr_fifo_if

// ===== verilog/acr_sync.sv
// Three-stage synchroniser whose output moves once stages two and three agree
module acr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q <= s3_r;
      end
   end
endmodule : acr_sync

// ===== verilog/acr_fifo.sv
// Dual-clock FIFO with gray-coded pointers and registered read data
module acr_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 16
) (
   input wire logic wr_clk,
   input wire logic wr_rst,
   input wire logic rd_clk,
   input wire logic rd_rst,
   acr_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wbin_r;
   logic [AW:0] wgray_r;
   logic [AW:0] rbin_r;
   logic [AW:0] rgray_r;
   logic [AW:0] wq;
   logic [AW:0] rq;
   logic [AW:0] wbin_nxt;
   logic [AW:0] rbin_nxt;
   logic [W-1:0] rdata_r;
   logic push;
   logic pop;

   assign f.wr_ready = (wgray_r != {~rq[AW:AW-1], rq[AW-2:0]});
   assign f.rd_valid = (rgray_r != wq);
   assign f.rd_data = rdata_r;
   assign push = f.wr_valid & f.wr_ready;
   assign pop = f.rd_valid & f.rd_ready;
   assign wbin_nxt = wbin_r + (AW + 1)'(push);
   assign rbin_nxt = rbin_r + (AW + 1)'(pop);

   always_ff @(posedge wr_clk)
   begin
      if (push)
         mem_r[wbin_r[AW-1:0]] <= f.wr_data;
   end

   always_ff @(posedge wr_clk)
   begin
      if (wr_rst)
      begin
         wbin_r <= '0;
         wgray_r <= '0;
      end
      else
      begin
         wbin_r <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // Head word is re-read every read edge, so it is stable well before a pop
   always_ff @(posedge rd_clk)
   begin
      if (rd_rst)
      begin
         rbin_r <= '0;
         rgray_r <= '0;
         rdata_r <= '0;
      end
      else
      begin
         rbin_r <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
         rdata_r <= mem_r[rbin_r[AW-1:0]];
      end
   end

   acr_sync #(.W(AW + 1)) u_wsync (.clk(rd_clk), .rst(rd_rst), .d(wgray_r), .q(wq));
   acr_sync #(.W(AW + 1)) u_rsync (.clk(wr_clk), .rst(wr_rst), .d(rgray_r), .q(rq));
endmodule : acr_fifo

// ===== verilog/acr_top.sv
// Conversion control, result buffering and serial result readout
`include "acr_consts.svh"
module acr_top
   import acr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic link_sclk,
   input wire logic convert_start_n,
   input wire logic [`ACR_RES_BITS-1:0] analog_input,
   output logic busy,
   output logic track_mode,
   output logic power_down,
   output logic conv_stall,
   output logic serial_result_out,
   output logic serial_result_oe
);
   localparam acr_cnt_t CONV_LAST = `ACR_CNT_W'(`ACR_CONV_HS_CYC - 1);
   localparam acr_cnt_t WAKE_LAST = `ACR_CNT_W'(`ACR_WAKE_CYC - 1);
   localparam acr_cnt_t CONV_CYC = `ACR_CNT_W'(`ACR_CONV_HS_CYC);
   localparam acr_cnt_t WAKE_CYC = `ACR_CNT_W'(`ACR_WAKE_CYC);
   localparam acr_edge_t LAST_EDGE = `ACR_EDGE_W'(`ACR_WORD_BITS - 1);
   localparam acr_edge_t LOAD_EDGE = `ACR_EDGE_W'(`ACR_WORD_BITS - `ACR_RES_BITS - 1);

   logic cs_n_q;
   logic cs_n_d_r;
   logic cs_fall;
   logic cs_rise;
   logic start_ok;
   logic conv_done;
   logic hold_now;
   acr_result_t ain_q;
   acr_result_t sample_r;
   acr_state_t state_r;
   acr_cnt_t cnt_r;
   logic pend_r;
   logic busy_r;
   logic push_r;
   acr_cnt_t conv_len_r;
   acr_cnt_t wake_len_r;

   logic sclk_fall;
   logic link_rst;
   acr_edge_t edge_cnt_r;
   acr_result_t shift_r;
   acr_result_t word;
   logic out_r;
   logic oe_r;

   acr_fifo_if #(.W(`ACR_RES_BITS)) fif ();

   acr_sync #(.RST_VAL(`ACR_CS_N_RST)) u_cs_sync (
      .clk(sys_clk),
      .rst(sys_rst),
      .d(convert_start_n),
      .q(cs_n_q)
   );

   // Host must hold the input steady while a conversion may start
   acr_sync #(.W(`ACR_RES_BITS)) u_ain_sync (
      .clk(sys_clk),
      .rst(sys_rst),
      .d(analog_input),
      .q(ain_q)
   );

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         cs_n_d_r <= `ACR_CS_N_RST;
      else
         cs_n_d_r <= cs_n_q;
   end

   assign cs_fall = cs_n_d_r & ~cs_n_q;
   assign cs_rise = ~cs_n_d_r & cs_n_q;
   // A start is refused only while the FIFO is full, so one taken in the cycle that pushes into the last free slot can lose its word
   assign start_ok = cs_fall & fif.wr_ready;
   assign conv_done = (state_r == ACR_CONV) && (cnt_r == '0);
   assign hold_now = ((state_r == ACR_TRACK) && start_ok) ||
                     ((state_r == ACR_WAKE) && (cnt_r == '0) && (pend_r || start_ok));

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_r <= ACR_TRACK;
         cnt_r <= '0;
      end
      else
      begin
         unique case (state_r)
            ACR_TRACK:
            begin
               if (start_ok)
               begin
                  state_r <= ACR_CONV;
                  cnt_r <= CONV_LAST;
               end
            end
            ACR_CONV:
            begin
               if (cnt_r == '0)
                  state_r <= cs_n_q ? ACR_TRACK : ACR_PDOWN;
               else
                  cnt_r <= cnt_r - 1'b1;
            end
            ACR_PDOWN:
            begin
               if (cs_rise)
               begin
                  state_r <= ACR_WAKE;
                  cnt_r <= WAKE_LAST;
               end
            end
            ACR_WAKE:
            begin
               if (cnt_r != '0)
                  cnt_r <= cnt_r - 1'b1;
               else if (hold_now)
               begin
                  state_r <= ACR_CONV;
                  cnt_r <= CONV_LAST;
               end
               else
                  state_r <= ACR_TRACK;
            end
         endcase
      end
   end

   // A start that lands during wake-up is remembered; hold waits for wake-up
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         pend_r <= 1'b0;
      else if (state_r != ACR_WAKE || cnt_r == '0)
         pend_r <= 1'b0;
      else if (start_ok)
         pend_r <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         busy_r <= 1'b0;
      else if (conv_done)
         busy_r <= 1'b0;
      else if (start_ok && (state_r == ACR_TRACK || (state_r == ACR_WAKE && !pend_r)))
         busy_r <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         sample_r <= '0;
      else if (hold_now)
         sample_r <= ain_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         push_r <= 1'b0;
      else
         push_r <= conv_done;
   end

   assign fif.wr_valid = push_r;
   assign fif.wr_data = sample_r;
   assign busy = busy_r;
   assign track_mode = (state_r == ACR_TRACK) || (state_r == ACR_WAKE && !pend_r);
   assign power_down = (state_r == ACR_PDOWN);
   assign conv_stall = ~fif.wr_ready;

   acr_fifo #(.W(`ACR_RES_BITS), .DEPTH(`ACR_FIFO_DEPTH)) u_fifo (
      .wr_clk(sys_clk),
      .wr_rst(sys_rst),
      .rd_clk(sclk_fall),
      .rd_rst(link_rst),
      .f(fif)
   );

   // One inversion lets every link flop share the falling serial clock edge
   assign sclk_fall = ~link_sclk;

   // The link clock only runs in frames, so reset reaches it on its own edges
   acr_sync u_lrst_sync (
      .clk(sclk_fall),
      .rst(1'b0),
      .d(sys_rst),
      .q(link_rst)
   );

   // Empty FIFO at load time yields an all-zero word rather than stale data
   assign word = fif.rd_valid ? fif.rd_data : '0;
   // Popping at the fourth edge gives the pointer sync three frame edges to settle
   assign fif.rd_ready = (edge_cnt_r == LOAD_EDGE);

   always_ff @(posedge sclk_fall)
   begin
      if (link_rst)
         edge_cnt_r <= '0;
      else if (edge_cnt_r == LAST_EDGE)
         edge_cnt_r <= '0;
      else
         edge_cnt_r <= edge_cnt_r + 1'b1;
   end

   // Drive drops on the sixteenth fall; the old bit stays until that edge
   always_ff @(posedge sclk_fall)
   begin
      if (link_rst)
         oe_r <= 1'b0;
      else
         oe_r <= (edge_cnt_r != LAST_EDGE);
   end

   always_ff @(posedge sclk_fall)
   begin
      if (link_rst)
      begin
         out_r <= 1'b0;
         shift_r <= '0;
      end
      else if (edge_cnt_r < LOAD_EDGE || edge_cnt_r == LAST_EDGE)
         out_r <= 1'b0;
      else if (edge_cnt_r == LOAD_EDGE)
      begin
         out_r <= word[`ACR_RES_BITS-1];
         shift_r <= {word[`ACR_RES_BITS-2:0], 1'b0};
      end
      else
      begin
         out_r <= shift_r[`ACR_RES_BITS-1];
         shift_r <= {shift_r[`ACR_RES_BITS-2:0], 1'b0};
      end
   end

   assign serial_result_out = out_r;
   assign serial_result_oe = oe_r;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         conv_len_r <= '0;
      else if (state_r == ACR_CONV)
         conv_len_r <= conv_len_r + 1'b1;
      else
         conv_len_r <= '0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         wake_len_r <= '0;
      else if (state_r == ACR_WAKE)
         wake_len_r <= wake_len_r + 1'b1;
      else
         wake_len_r <= '0;
   end

   property p_busy_rise;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == ACR_TRACK && start_ok) |=> busy_r ##1 busy_r;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise on start");

   property p_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == ACR_TRACK && start_ok) |=> !track_mode && sample_r == $past(ain_q);
   endproperty
   a_hold: assert property (p_hold) else $error("sample not held at start");

   property p_conv_len;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(state_r == ACR_CONV) |-> conv_len_r == CONV_CYC;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_wake_len;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(state_r == ACR_WAKE) |-> wake_len_r == WAKE_CYC;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake-up length wrong");

   property p_busy_fall;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(busy_r) |-> push_r && $past(conv_len_r) == CONV_CYC - 1'b1;
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy fell without result");

   property p_track;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(busy_r) && $past(cs_n_q) |-> track_mode && !power_down;
   endproperty
   a_track: assert property (p_track) else $error("not tracking after conversion");

   property p_pdown;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(busy_r) && !$past(cs_n_q) |-> power_down ##1 (power_down || cs_rise || $past(cs_rise));
   endproperty
   a_pdown: assert property (p_pdown) else $error("no power-down with start low");

   property p_wake;
      @(posedge sys_clk) disable iff (sys_rst)
      power_down && cs_rise |=> !power_down && !busy_r;
   endproperty
   a_wake: assert property (p_wake) else $error("rising start did not wake");

   property p_oe_frame;
      @(posedge sclk_fall) disable iff (link_rst)
      (edge_cnt_r != '0) |-> oe_r;
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("output not driven in frame");

   property p_release;
      @(posedge sclk_fall) disable iff (link_rst)
      ($past(edge_cnt_r) == LAST_EDGE) |-> !oe_r && edge_cnt_r == '0;
   endproperty
   a_release: assert property (p_release) else $error("output not released after word");

   property p_lead;
      @(posedge sclk_fall) disable iff (link_rst)
      (edge_cnt_r != '0 && edge_cnt_r <= LOAD_EDGE) |-> !out_r;
   endproperty
   a_lead: assert property (p_lead) else $error("leading bit not zero");

   property p_msb;
      @(posedge sclk_fall) disable iff (link_rst)
      ($past(edge_cnt_r) == LOAD_EDGE && $past(fif.rd_valid)) |-> out_r == $past(fif.rd_data[`ACR_RES_BITS-1]);
   endproperty
   a_msb: assert property (p_msb) else $error("result top bit not first");
endmodule : acr_top

// ===== testbench/acr_host_model.sv
// Host model: drives convert start and clocks result words out of the link
module acr_host_model
(
   input wire logic sys_clk,
   output logic link_sclk,
   output logic convert_start_n,
   input wire logic serial_result_out,
   input wire logic serial_result_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 15;
   logic last_bit = 1'b0;
   // No pull on the line: once released it shows the inverse of the last driven bit
   wire logic line_lvl = serial_result_oe ? serial_result_out : ~last_bit;

   initial
   begin
      link_sclk = 1'b0;
      convert_start_n = 1'b1;
   end

   always @(serial_result_out or serial_result_oe)
      if (serial_result_oe)
         last_bit = serial_result_out;

   // Clock stands still outside these bursts
   task automatic falls(input int n);
      repeat (n)
      begin
         #HALF link_sclk = 1'b1;
         #HALF link_sclk = 1'b0;
      end
   endtask : falls

   task automatic set_start(input logic lvl);
      @(posedge sys_clk) convert_start_n <= lvl;
   endtask : set_start

   task automatic acquire();
      repeat (188) @(posedge sys_clk);
   endtask : acquire

   // Samples before driving the fall, so the bit seen is the one held across it
   task automatic read_word(output logic [15:0] word, output logic [15:0] oe_seen);
      for (int k = 15; k >= 0; k--)
      begin
         #HALF link_sclk = 1'b1;
         #HALF word[k] = line_lvl;
         link_sclk = 1'b0;
         #2 oe_seen[k] = serial_result_oe;
      end
   endtask : read_word
endmodule : acr_host_model

// ===== testbench/acr_top_bench.sv
// Self-checking bench for the converter control and serial readout block
`include "acr_consts.svh"
module acr_top_bench
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CONV_CYC = 1000;
   localparam int WAKE_CYC = 750;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic link_sclk, convert_start_n, busy, track_mode, power_down, conv_stall;
   logic serial_result_out, serial_result_oe;
   acr_result_t analog_input = '0;
   acr_result_t exp_q[$];
   int error_cnt = 0;
   int tests_run = 0;
   int seed_val;

   always #4 sys_clk = ~sys_clk;

   acr_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_sclk(link_sclk),
      .convert_start_n(convert_start_n), .analog_input(analog_input), .busy(busy),
      .track_mode(track_mode), .power_down(power_down), .conv_stall(conv_stall),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

   acr_host_model u_host (.sys_clk(sys_clk), .link_sclk(link_sclk), .convert_start_n(convert_start_n),
      .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic cmp_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_len(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask : cmp_len

   // Bounded wait on busy or power_down; n is the number of cycles waited
   task automatic wait_lvl(input bit on_pd, input logic lvl, input int limit, output int n);
      n = 0;
      while ((on_pd ? power_down : busy) !== lvl && n < limit)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_lvl

   task automatic convert(input acr_result_t val, input logic stay_low, output int len);
      int n;
      @(posedge sys_clk) analog_input <= val;
      u_host.set_start(1'b0);
      wait_lvl(1'b0, 1'b1, 12, n);
      cmp_len(n, 1, 8);
      cmp_bit(track_mode, 1'b0);
      if (!stay_low)
         u_host.set_start(1'b1);
      wait_lvl(1'b0, 1'b0, 2000, len);
      cmp_bit(track_mode, !stay_low);
      cmp_bit(power_down, stay_low);
      exp_q.push_back(val);
   endtask : convert

   task automatic drain();
      logic [15:0] w;
      logic [15:0] oe;
      bit skipped;
      skipped = 1'b0;
      while (exp_q.size() > 0)
      begin
         u_host.read_word(w, oe);
         cmp_word(oe, 16'hfffe);
         // With the link clock stopped, a fresh push may not be across by the fourth fall
         if (w[14:0] === 15'h0000 && !skipped && exp_q[0] !== '0)
            skipped = 1'b1;
         else
            cmp_word({1'b0, w[14:0]}, {4'h0, exp_q.pop_front()});
      end
      u_host.read_word(w, oe);
      cmp_word({1'b0, w[14:0]}, 16'h0000);
   endtask : drain

   initial
   begin
      int n;
      seed_val = $urandom(31);
      fork
         u_host.falls(8);
         repeat (12) @(posedge sys_clk);
      join
      @(posedge sys_clk) sys_rst <= 1'b0;
      // Link reset leaves through its own sync, so four idle falls clear it before any frame
      u_host.falls(4);
      @(negedge sys_clk);
      cmp_bit(busy, 1'b0);
      cmp_bit(power_down, 1'b0);
      cmp_bit(track_mode, 1'b1);
      cmp_bit(conv_stall, 1'b0);
      cmp_bit(serial_result_oe, 1'b0);
      for (int i = 0; i < 16; i++)
      begin
         convert(i == 0 ? 12'hfff : (i == 15 ? 12'h000 : acr_result_t'($urandom)), 1'b0, n);
         cmp_len(n, CONV_CYC, CONV_CYC);
         u_host.acquire();
      end
      cmp_bit(conv_stall, 1'b1);
      u_host.set_start(1'b0);
      repeat (20) @(negedge sys_clk);
      cmp_bit(busy, 1'b0);
      u_host.set_start(1'b1);
      u_host.acquire();
      drain();
      repeat (10) @(negedge sys_clk);
      cmp_bit(conv_stall, 1'b0);
      convert(12'h5a5, 1'b1, n);
      cmp_len(n, CONV_CYC, CONV_CYC);
      u_host.set_start(1'b1);
      wait_lvl(1'b1, 1'b0, 12, n);
      cmp_len(n, 1, 8);
      cmp_bit(track_mode, 1'b1);
      convert(12'ha5a, 1'b0, n);
      cmp_len(n, CONV_CYC + WAKE_CYC - 24, CONV_CYC + WAKE_CYC);
      u_host.acquire();
      convert(12'h3c3, 1'b1, n);
      u_host.set_start(1'b1);
      repeat (WAKE_CYC + 20) @(negedge sys_clk);
      cmp_bit(track_mode, 1'b1);
      cmp_bit(power_down, 1'b0);
      convert(12'h777, 1'b0, n);
      cmp_len(n, CONV_CYC, CONV_CYC);
      u_host.acquire();
      drain();
      end_of_test();
   end

   // Expected run is about 200 us; three times that means a hang
   initial
   begin
      #600000;
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
   end
endmodule : acr_top_bench
